// file: core/amp_protect_pkg.sv
// Package for the power-amplifier protection block: register map, control and
// status layouts, reset values and timing constants.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
package amp_protect_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int BIAS_HOLD_NS    = 1000000;
  localparam int BIAS_HOLD_CYCLES = (BIAS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES     = 2;

  // ********************************************************************
  // Register map (byte addresses)
  // ********************************************************************
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] CLEAR_OFFSET  = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam int         ADDR_WIDTH    = 8;
  localparam int         CTRL_WIDTH    = 10;
  localparam int         STATUS_WIDTH  = 7;
  localparam int         CLEAR_BIT     = 0;

  // ********************************************************************
  // Field layouts
  // ********************************************************************
  typedef struct packed {
    logic ac10vRange;
    logic outputOn;
    logic dc1000Range;
    logic dcFunctionSel;
    logic freqRangeLsb;
    logic lowFreqGain;
    logic biasEnable;
    logic hvSupplyOffCmd;
    logic positive;
    logic outputClampRequest;
  } ctrl_s;

  typedef struct packed {
    logic hvEnableNeg;
    logic biasHold;
    logic supplyFail15;
    logic supplyFail400;
    logic limitDetect;
    logic limitLatch;
    logic limitStatusN;
  } status_s;

  // Supply held off after reset until software asks for it.
  localparam ctrl_s CTRL_RESET = '{hvSupplyOffCmd: 1'b1, default: 1'b0};

  // Overload flags read high when healthy, so their synchronisers reset high.
  localparam logic [1:0] FLAG_IDLE = 2'b11;

endpackage

// file: core/amplifier_protection_logic.sv
// Control and protection logic of the power-amplifier assembly behind an APB slave.
// Assumes one 100 MHz clock, synchronous active-low reset, and asynchronous pin inputs.
//
// Behaviour
// - DC 1000V range with output off removes step-up transformer drive.
// - Polarity relay drive is XNOR of positive and clamp request.
// - Clamp request high blocks modulator drive to the DC modulator.
// - Negative supply enable high on 400V or 15V failure or supply-off command, low otherwise.
// - Each supply re-enable holds bias cutoff low about 1 ms.
// - Active-low limit status asserts when any of nine detectors trips.
// - Limit detect is NOR of high-voltage overload flag and DC function.
// - High limit detect asserts amplifier input limit on the next clock.
// - Limit latch set while detect high; drives status and input limit.
// - Limit status asserts on low-voltage flag low in AC 10V range.
// - Clear pulses reset the latch once limit detect is low.
// - Kilovolt gain select low only when the 100 kHz band is chosen.
// - Logic one is the 0V level, logic zero the -15V level.
// - A relay drive at one energizes its relay, at zero releases it.

`timescale 1ns/1ns
`default_nettype none

module amplifier_protection_logic
  import amp_protect_pkg::*;
#(
  parameter int OTHER_DETECTORS = 7,
  parameter int BIAS_HOLD       = BIAS_HOLD_CYCLES
) (
  input  wire  logic                       clk,
  input  wire  logic                       rstn,
  input  wire  logic                       psel,
  input  wire  logic                       penable,
  input  wire  logic                       pwrite,
  input  wire  logic [ADDR_WIDTH-1:0]      paddr,
  input  wire  logic [31:0]                pwdata,
  output logic       [31:0]                prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire  logic                       hvAmpOverloadFlag,
  input  wire  logic                       lvAmpOverloadFlag,
  input  wire  logic                       supplyFail400,
  input  wire  logic                       supplyFail15,
  input  wire  logic                       modulatorDriveIn,
  input  wire  logic [OTHER_DETECTORS-1:0] otherLimitDetect,
  output logic                             polarityRelayDrive,
  output logic                             modulatorDrive,
  output logic                             stepUpDriveEnable,
  output logic                             hvEnableNeg,
  output logic                             biasCutoff,
  output logic                             ampInputLimit,
  output logic                             limitStatusN,
  output logic                             lowFreqGain,
  output logic                             kilovoltGainSel
);

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  localparam int NPIN = 5 + OTHER_DETECTORS;
  localparam logic [NPIN-1:0] PIN_IDLE = NPIN'(FLAG_IDLE);

  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] syncA_reg;
  logic [NPIN-1:0] syncB_reg;

  assign pinRaw = {otherLimitDetect, modulatorDriveIn, supplyFail15, supplyFail400,
                   lvAmpOverloadFlag, hvAmpOverloadFlag};

  // Each pin gets its own two-stage chain; the first stage feeds only the second.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : gSync
      always_ff @(posedge clk) begin
        if (!rstn) begin
          syncA_reg[gi] <= PIN_IDLE[gi];
          syncB_reg[gi] <= PIN_IDLE[gi];
        end else begin
          syncA_reg[gi] <= pinRaw[gi];
          syncB_reg[gi] <= syncA_reg[gi];
        end
      end
    end
  endgenerate

  logic                       hvFlagS;
  logic                       lvFlagS;
  logic                       fail400S;
  logic                       fail15S;
  logic                       modDriveS;
  logic [OTHER_DETECTORS-1:0] otherS;

  assign hvFlagS   = syncB_reg[0];
  assign lvFlagS   = syncB_reg[1];
  assign fail400S  = syncB_reg[2];
  assign fail15S   = syncB_reg[3];
  assign modDriveS = syncB_reg[4];
  assign otherS    = syncB_reg[NPIN-1:5];

  // ********************************************************************
  // APB slave
  // ********************************************************************
  ctrl_s   ctrl_reg;
  status_s statusNow;
  logic    clearPulse_reg;
  logic    setupPhase;
  logic    accessDone;
  logic    addrHit;

  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign addrHit    = (paddr == CTRL_OFFSET) || (paddr == CLEAR_OFFSET) ||
                      (paddr == STATUS_OFFSET);

  // Zero wait states: pready rises in the access phase right after setup.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !addrHit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata <= 32'h0;
    end else if (setupPhase && !pwrite) begin
      case (paddr)
        CTRL_OFFSET:   prdata <= {{(32-CTRL_WIDTH){1'b0}}, ctrl_reg};
        STATUS_OFFSET: prdata <= {{(32-STATUS_WIDTH){1'b0}}, statusNow};
        default:       prdata <= 32'h0;
      endcase
    end else if (accessDone) begin
      prdata <= 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (accessDone && pwrite && paddr == CTRL_OFFSET) begin
      ctrl_reg <= ctrl_s'(pwdata[CTRL_WIDTH-1:0]);
    end
  end

  // A write of one to the clear register is one clock pulse on the latch-clear line.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      clearPulse_reg <= 1'b0;
    end else begin
      clearPulse_reg <= accessDone && pwrite && paddr == CLEAR_OFFSET
                        && pwdata[CLEAR_BIT];
    end
  end

  // ********************************************************************
  // Limit detection and latch
  // ********************************************************************
  logic limitDetect;
  logic limitLatch_reg;
  logic lvTrip;
  logic limitAny;

  assign limitDetect = !(hvFlagS || ctrl_reg.dcFunctionSel);
  assign lvTrip      = !lvFlagS && ctrl_reg.ac10vRange;
  assign limitAny    = limitLatch_reg || lvTrip || (|otherS);

  // Set dominates: a clear pulse in a cycle with detect high leaves the latch set.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      limitLatch_reg <= 1'b0;
    end else if (limitDetect) begin
      limitLatch_reg <= 1'b1;
    end else if (clearPulse_reg) begin
      limitLatch_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ampInputLimit <= 1'b0;
      limitStatusN  <= 1'b1;
    end else begin
      ampInputLimit <= limitDetect || limitLatch_reg;
      limitStatusN  <= !limitAny;
    end
  end

  // ********************************************************************
  // Supply enable and bias hold-off
  // ********************************************************************
  localparam int BCW = $clog2(BIAS_HOLD + 1);

  logic           hvEnNegNext;
  logic           hvEnNegPrev_reg;
  logic [BCW-1:0] biasCount_reg;
  logic           biasHold;
  logic           reEnable;

  assign hvEnNegNext = fail400S || fail15S || ctrl_reg.hvSupplyOffCmd;
  assign biasHold    = biasCount_reg != '0;
  assign reEnable    = hvEnNegPrev_reg && !hvEnNegNext;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hvEnNegPrev_reg <= 1'b1;
    end else begin
      hvEnNegPrev_reg <= hvEnNegNext;
    end
  end

  // The hold restarts on every re-enable so the supply can build up before load returns.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      biasCount_reg <= '0;
    end else if (reEnable) begin
      biasCount_reg <= BCW'(BIAS_HOLD);
    end else if (biasHold) begin
      biasCount_reg <= biasCount_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hvEnableNeg <= 1'b1;
    end else begin
      hvEnableNeg <= hvEnNegNext;
    end
  end

  // Cutoff is forced low in the re-enable cycle too, before the counter has loaded.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      biasCutoff <= 1'b0;
    end else begin
      biasCutoff <= ctrl_reg.biasEnable && !biasHold && !reEnable;
    end
  end

  // ********************************************************************
  // Polarity, modulator, step-up drive and gain select
  // ********************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      polarityRelayDrive <= 1'b0;
    end else begin
      polarityRelayDrive <= !(ctrl_reg.positive ^ ctrl_reg.outputClampRequest);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      modulatorDrive <= 1'b0;
    end else begin
      modulatorDrive <= modDriveS && ctrl_reg.dc1000Range
                        && !ctrl_reg.outputClampRequest;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stepUpDriveEnable <= 1'b0;
    end else begin
      stepUpDriveEnable <= ctrl_reg.dc1000Range && ctrl_reg.outputOn;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lowFreqGain     <= 1'b0;
      kilovoltGainSel <= 1'b1;
    end else begin
      lowFreqGain     <= ctrl_reg.lowFreqGain;
      kilovoltGainSel <= !(!ctrl_reg.lowFreqGain && ctrl_reg.freqRangeLsb);
    end
  end

  // ********************************************************************
  // Status snapshot
  // ********************************************************************
  always_comb begin
    statusNow               = '0;
    statusNow.limitStatusN  = limitStatusN;
    statusNow.limitLatch    = limitLatch_reg;
    statusNow.limitDetect   = limitDetect;
    statusNow.supplyFail400 = fail400S;
    statusNow.supplyFail15  = fail15S;
    statusNow.biasHold      = biasHold;
    statusNow.hvEnableNeg   = hvEnableNeg;
  end

endmodule

`default_nettype wire

// file: bench/amp_protect_properties.sv
// Checker for the amplifier protection block, bound to its top module.
// Assumes the single clk domain and the synchronous active-low rstn.
`timescale 1ns/1ns
`default_nettype none
module amp_protect_properties
  import amp_protect_pkg::*;
#(
  parameter int OTHER_DETECTORS = 7
) (
  input wire logic                       clk,
  input wire logic                       rstn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       supplyFail400,
  input wire logic                       supplyFail15,
  input wire logic [OTHER_DETECTORS-1:0] otherLimitDetect,
  input wire logic                       hvEnableNeg,
  input wire logic                       biasCutoff,
  input wire logic                       ampInputLimit,
  input wire logic                       limitStatusN,
  input wire logic                       lowFreqGain,
  input wire logic                       kilovoltGainSel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic wrAcc;
  assign wrAcc = psel && penable && pwrite && pready;
  a_setup_gets_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_error_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("slave error outside access");
  a_detector_status: assert property ((otherLimitDetect != '0) [*4]
    |-> !limitStatusN)
    else $error("detector trip not reported");
  a_supply_fail_off: assert property ((supplyFail400 || supplyFail15) [*4]
    |-> hvEnableNeg)
    else $error("supply left enabled on failure");
  a_bias_hold_low: assert property ($fell(hvEnableNeg) |-> !biasCutoff [*8])
    else $error("bias cutoff released too early");
  a_latch_to_status: assert property ($rose(ampInputLimit) |=> !limitStatusN)
    else $error("input limit without limit status");
  a_gain_decode: assert property (lowFreqGain |-> kilovoltGainSel)
    else $error("gain select low with low band gain");
  a_gain_on_write: assert property ($changed(kilovoltGainSel)
    |-> $past(wrAcc) || $past(wrAcc, 2))
    else $error("gain select moved without a write");
endmodule
`default_nettype wire

// file: bench/cpu_link_model.sv
// Model of the controlling processor as an APB master.
// Assumes the caller enters xfer in a process synchronised to clk.
`timescale 1ns/1ns
`default_nettype none
module cpu_link_model (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Released address and write-data lines show the inverse so stale values never look valid.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_amplifier_protection_logic.sv
// Self-checking bench for the amplifier protection block.
// Assumes the processor model drives APB and the bench drives the pins.
`timescale 1ns/1ns
`default_nettype none
module tb_amplifier_protection_logic;
  import amp_protect_pkg::*;
  localparam int BH = 20;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic hvAmpOverloadFlag, lvAmpOverloadFlag, supplyFail400, supplyFail15, modulatorDriveIn;
  logic [6:0] otherLimitDetect;
  logic polarityRelayDrive, modulatorDrive, stepUpDriveEnable, hvEnableNeg, biasCutoff;
  logic ampInputLimit, limitStatusN, lowFreqGain, kilovoltGainSel;
  int error_cnt = 0;
  int checks = 0;
  // Each row: control word, then relay, modulator, step-up, band gain, gain select.
  logic [14:0] rows [9] = '{15'h0811, 15'h0821, 15'h0841, 15'h0871, 15'h1849,
                            15'h3875, 15'h0c10, 15'h0e13, 15'h0a13};
  amplifier_protection_logic #(.BIAS_HOLD(BH)) u_dut (.clk, .rstn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hvAmpOverloadFlag,
    .lvAmpOverloadFlag, .supplyFail400, .supplyFail15, .modulatorDriveIn, .otherLimitDetect,
    .polarityRelayDrive, .modulatorDrive, .stepUpDriveEnable, .hvEnableNeg, .biasCutoff,
    .ampInputLimit, .limitStatusN, .lowFreqGain, .kilovoltGainSel);
  cpu_link_model u_cpu (.clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
    .paddr, .pwdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_cpu.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    step(5000);
    error_cnt++;
    summarize();
  end
  initial begin
    {hvAmpOverloadFlag, lvAmpOverloadFlag, modulatorDriveIn} = 3'b111;
    {supplyFail400, supplyFail15, rstn} = 3'b000;
    otherLimitDetect = 7'h00;
    step(10);
    chk("reset", 32'h1c, 32'({hvEnableNeg, limitStatusN, kilovoltGainSel, biasCutoff,
        pready}));
    rstn <= 1'b1;
    u_cpu.xfer(1'b0, CTRL_OFFSET, 32'h0, rd, er);
    chk("ctrl", 32'(CTRL_RESET), rd);
    foreach (rows[i]) begin
      wr(CTRL_OFFSET, 32'(rows[i][14:5]));
      step(4);
      chk("outs", 32'(rows[i][4:0]), 32'({polarityRelayDrive, modulatorDrive,
          stepUpDriveEnable, lowFreqGain, kilovoltGainSel}));
    end
    wr(CTRL_OFFSET, 32'h0c2);
    modulatorDriveIn <= 1'b0;
    step(4);
    chk("moddrv", 32'h0, 32'(modulatorDrive));
    modulatorDriveIn <= 1'b1;
    step(4);
    chk("moddrv", 32'h1, 32'(modulatorDrive));
    wr(CTRL_OFFSET, 32'h040);
    wr(CLEAR_OFFSET, 32'h1);
    step(4);
    chk("limst", 32'h1, 32'(limitStatusN));
    wr(CTRL_OFFSET, 32'h000);
    hvAmpOverloadFlag <= 1'b0;
    step(5);
    chk("limit", 32'h2, 32'({ampInputLimit, limitStatusN}));
    wr(CLEAR_OFFSET, 32'h1);
    step(3);
    chk("limit", 32'h2, 32'({ampInputLimit, limitStatusN}));
    hvAmpOverloadFlag <= 1'b1;
    step(4);
    chk("limit", 32'h2, 32'({ampInputLimit, limitStatusN}));
    for (int k = 0; k < 4 && limitStatusN !== 1'b1; k++) begin
      wr(CLEAR_OFFSET, 32'h1);
      step(4);
    end
    chk("limit", 32'h1, 32'({ampInputLimit, limitStatusN}));
    wr(CTRL_OFFSET, 32'h240);
    lvAmpOverloadFlag <= 1'b0;
    step(4);
    chk("ac10", 32'h0, 32'(limitStatusN));
    lvAmpOverloadFlag <= 1'b1;
    step(4);
    chk("ac10", 32'h1, 32'(limitStatusN));
    for (int i = 0; i < 7; i++) begin
      otherLimitDetect <= 7'(1 << i);
      step(5);
      chk("trip", 32'h0, 32'(limitStatusN));
      otherLimitDetect <= 7'h00;
      step(5);
    end
    wr(CTRL_OFFSET, 32'h048);
    step(BH + 5);
    chk("supply", 32'h1, 32'({hvEnableNeg, biasCutoff}));
    supplyFail400 <= 1'b1;
    step(4);
    chk("fail400", 32'h1, 32'(hvEnableNeg));
    supplyFail400 <= 1'b0;
    step(BH / 2);
    chk("hold", 32'h0, 32'({hvEnableNeg, biasCutoff}));
    step(BH);
    chk("hold", 32'h1, 32'(biasCutoff));
    supplyFail15 <= 1'b1;
    step(4);
    chk("fail15", 32'h1, 32'(hvEnableNeg));
    supplyFail15 <= 1'b0;
    supplyFail400 <= 1'b1;
    wr(CTRL_OFFSET, 32'h040);
    for (int k = 0; k < 3; k++) begin
      wr(CTRL_OFFSET, 32'h044);
      wr(CTRL_OFFSET, 32'h040);
      step(2);
      chk("retry", 32'h2, 32'({hvEnableNeg, biasCutoff}));
    end
    wr(CTRL_OFFSET, 32'h044);
    supplyFail400 <= 1'b0;
    step(BH + 5);
    chk("held", 32'h2, 32'({hvEnableNeg, biasCutoff}));
    wr(CTRL_OFFSET, 32'h048);
    u_cpu.xfer(1'b0, 8'h0c, 32'h0, rd, er);
    chk("unmapped", 32'h1, 32'(er));
    chk("unmapdata", 32'h0, rd);
    step(BH + 5);
    u_cpu.xfer(1'b0, STATUS_OFFSET, 32'h0, rd, er);
    chk("status", 32'h1, 32'({rd[6], rd[0]}));
    rstn <= 1'b0;
    step(2);
    chk("rstmid", 32'h1c, 32'({hvEnableNeg, limitStatusN, kilovoltGainSel, biasCutoff,
        pready}));
    rstn <= 1'b1;
    u_cpu.xfer(1'b0, CTRL_OFFSET, 32'h0, rd, er);
    chk("ctrl", 32'(CTRL_RESET), rd);
    step(3);
    chk("rstlatch", 32'h1, 32'({ampInputLimit, limitStatusN}));
    summarize();
  end
endmodule
bind amplifier_protection_logic amp_protect_properties #(.OTHER_DETECTORS(OTHER_DETECTORS))
  u_props (.clk, .rstn, .psel, .penable, .pwrite, .pready, .pslverr, .supplyFail400,
  .supplyFail15, .otherLimitDetect, .hvEnableNeg, .biasCutoff, .ampInputLimit,
  .limitStatusN, .lowFreqGain, .kilovoltGainSel);
`default_nettype wire
